// *** design/e1lc_cmd_xfer.v ***
// Holds a command pulse until the target backplane clock has seen it on enough rising edges
module e1lc_cmd_xfer #(
    parameter EDGES = 2
) (
    // Clock and reset
    input  wire core_clk,
    input  wire nrst,
    // Command trigger from the register logic
    input  wire trig,
    // Backplane clock as a raw pin level
    input  wire bp_clk_pin,
    // Stretched command level toward the backplane logic
    output wire cmd_out,
    output wire busy
);

    reg        bp_meta_reg;
    reg        bp_sync_reg;
    reg        bp_prev_reg;
    reg        cmd_reg;
    reg  [3:0] edge_cnt_reg;
    reg  [3:0] edge_cnt_next;
    reg        cmd_next;
    wire       bp_rise;

    // First stage feeds only the second stage
    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            bp_meta_reg <= 1'b0;
            bp_sync_reg <= 1'b0;
            bp_prev_reg <= 1'b0;
        end
        else
        begin
            bp_meta_reg <= bp_clk_pin;
            bp_sync_reg <= bp_meta_reg;
            bp_prev_reg <= bp_sync_reg;
        end
    end

    assign bp_rise = bp_sync_reg & ~bp_prev_reg;

    always @*
    begin
        cmd_next      = cmd_reg;
        edge_cnt_next = edge_cnt_reg;
        if (trig)
        begin
            // A new command restarts the hold so it is never shortened
            cmd_next      = 1'b1;
            edge_cnt_next = 4'h0;
        end
        else if (cmd_reg && bp_rise)
        begin
            if (edge_cnt_reg == EDGES[3:0] - 4'h1)
            begin
                cmd_next      = 1'b0;
                edge_cnt_next = 4'h0;
            end
            else
            begin
                edge_cnt_next = edge_cnt_reg + 4'h1;
            end
        end
    end

    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cmd_reg      <= 1'b0;
            edge_cnt_reg <= 4'h0;
        end
        else
        begin
            cmd_reg      <= cmd_next;
            edge_cnt_reg <= edge_cnt_next;
        end
    end

    assign cmd_out = cmd_reg;
    assign busy    = cmd_reg;

endmodule

// *** design/e1lc_ctrl.v ***
// Line interface, elastic store command and line driver control registers on the parallel control port
`include "e1lc_regs.vh"

module e1lc_ctrl #(
    parameter BP_EDGES = `E1LC_BP_EDGES
) (
    // Clock and reset
    input  wire       core_clk,
    input  wire       nrst,
    // Parallel control port pins
    input  wire       cs_n,
    input  wire       rd_n,
    input  wire       wr_n,
    input  wire [7:0] addr,
    input  wire [7:0] data_in,
    output wire [7:0] data_out,
    output wire       data_oe,
    // Backplane clocks as pin levels
    input  wire       rx_backplane_clock,
    input  wire       tx_backplane_clock,
    // Elastic store pointer separation status, at least half a frame
    input  wire       rx_store_sep_ge_half,
    input  wire       tx_store_sep_ge_half,
    // Transmit clock selection inputs
    input  wire       tx_clock_loss_mux_ctrl,
    input  wire       tx_clock_lost,
    // Transmit line data
    input  wire       line_bit_tick,
    input  wire       tx_bipolar_in_pos,
    input  wire       tx_bipolar_in_neg,
    output wire       line_tx_out_a,
    output wire       line_tx_out_a_oe,
    output wire       line_tx_out_b,
    output wire       line_tx_out_b_oe,
    // Commands toward recovery, jitter attenuator and elastic stores
    output wire       line_if_reset,
    output wire       rx_store_align,
    output wire       tx_store_align,
    output wire       rx_store_reset,
    output wire       tx_store_reset,
    // Static settings
    output wire [4:0] rx_chan_monitor_sel,
    output wire       line_rx_sync_signal_mode,
    output wire       tx_clk_use_recovered,
    output wire       tx_clock_pin_ignored
);

    // Synchronised port and pin inputs
    reg  [18:0] port_meta_reg;
    reg  [18:0] port_sync_reg;
    reg  [3:0]  misc_meta_reg;
    reg  [3:0]  misc_sync_reg;
    reg         wr_act_prev_reg;

    // Registers
    reg  [7:0]  line_reset_store_align_monitor_ctrl_reg;
    reg  [7:0]  line_driver_clock_source_ctrl_reg;
    reg  [7:0]  data_out_reg;
    reg         data_oe_reg;
    reg         line_if_reset_reg;
    reg         rx_align_trig_reg;
    reg         tx_align_trig_reg;
    reg         rx_reset_trig_reg;
    reg         tx_reset_trig_reg;
    reg         tx_clk_rec_reg;
    reg         tx_pin_ign_reg;

    // Line pattern state
    reg         pat_bit_reg;
    reg         mark_pol_reg;
    reg         line_a_reg;
    reg         line_a_oe_reg;
    reg         line_b_reg;
    reg         line_b_oe_reg;

    wire        cs_s;
    wire        rd_s;
    wire        wr_s;
    wire [7:0]  addr_s;
    wire [7:0]  wdata_s;
    wire        tx_pos_s;
    wire        tx_neg_s;
    wire        rx_sep_s;
    wire        tx_sep_s;
    wire        wr_act;
    wire        wr_take;
    wire        rd_act;
    wire [7:0]  mon_wr;
    wire [7:0]  drv_wr;
    wire        mark;
    wire        mark_pos;
    wire        mark_neg;
    wire        open_drain;
    wire [8:0]  rd_map;

    // Rising bit detection against the stored value
    function rose;
        input [7:0] old_val;
        input [7:0] new_val;
        input integer pos;
        begin
            rose = ~old_val[pos] & new_val[pos];
        end
    endfunction

    // Readback of a mapped address; unmapped reads leave the bus undriven
    function [8:0] read_map;
        input [7:0] a;
        input [7:0] mon_val;
        input [7:0] drv_val;
        begin
            if (a == `E1LC_LINE_RST_ALIGN_MON_ADDR)
                read_map = {1'b1, mon_val};
            else if (a == `E1LC_DRV_CLK_SRC_ADDR)
                read_map = {1'b1, drv_val & `E1LC_DRV_CLK_SRC_MASK};
            else
                read_map = 9'h000;
        end
    endfunction

    // Port pins are asynchronous: two stages, reset inactive so no false write follows reset
    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            port_meta_reg <= 19'h00000;
            port_sync_reg <= 19'h00000;
            misc_meta_reg <= 4'h0;
            misc_sync_reg <= 4'h0;
        end
        else
        begin
            port_meta_reg <= {~cs_n, ~rd_n, ~wr_n, addr, data_in};
            port_sync_reg <= port_meta_reg;
            misc_meta_reg <= {tx_bipolar_in_pos, tx_bipolar_in_neg, rx_store_sep_ge_half, tx_store_sep_ge_half};
            misc_sync_reg <= misc_meta_reg;
        end
    end

    assign cs_s     = port_sync_reg[18];
    assign rd_s     = port_sync_reg[17];
    assign wr_s     = port_sync_reg[16];
    assign addr_s   = port_sync_reg[15:8];
    assign wdata_s  = port_sync_reg[7:0];
    assign tx_pos_s = misc_sync_reg[3];
    assign tx_neg_s = misc_sync_reg[2];
    assign rx_sep_s = misc_sync_reg[1];
    assign tx_sep_s = misc_sync_reg[0];

    // Write is taken as the strobe ends, when address and data have long settled
    assign wr_act  = cs_s & wr_s;
    assign wr_take = wr_act_prev_reg & ~wr_act;
    assign rd_act  = cs_s & rd_s & ~wr_s;
    assign mon_wr  = (wr_take && addr_s == `E1LC_LINE_RST_ALIGN_MON_ADDR) ?
                     wdata_s : line_reset_store_align_monitor_ctrl_reg;
    assign drv_wr  = (wr_take && addr_s == `E1LC_DRV_CLK_SRC_ADDR) ?
                     wdata_s : line_driver_clock_source_ctrl_reg;

    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            wr_act_prev_reg                         <= 1'b0;
            line_reset_store_align_monitor_ctrl_reg <= `E1LC_LINE_RST_ALIGN_MON_RST;
            line_driver_clock_source_ctrl_reg       <= `E1LC_DRV_CLK_SRC_RST;
            line_if_reset_reg                       <= 1'b0;
            rx_align_trig_reg                       <= 1'b0;
            tx_align_trig_reg                       <= 1'b0;
            rx_reset_trig_reg                       <= 1'b0;
            tx_reset_trig_reg                       <= 1'b0;
        end
        else
        begin
            wr_act_prev_reg                         <= wr_act;
            line_reset_store_align_monitor_ctrl_reg <= mon_wr;
            line_driver_clock_source_ctrl_reg       <= drv_wr & `E1LC_DRV_CLK_SRC_MASK;
            line_if_reset_reg <= rose(line_reset_store_align_monitor_ctrl_reg, mon_wr, `E1LC_LINE_IF_RESET_BIT);
            rx_align_trig_reg <= rose(line_reset_store_align_monitor_ctrl_reg, mon_wr, `E1LC_RX_ALIGN_BIT)
                                 & ~rx_sep_s;
            tx_align_trig_reg <= rose(line_reset_store_align_monitor_ctrl_reg, mon_wr, `E1LC_TX_ALIGN_BIT)
                                 & ~tx_sep_s;
            rx_reset_trig_reg <= rose(line_driver_clock_source_ctrl_reg, drv_wr, `E1LC_RX_STORE_RESET_BIT);
            tx_reset_trig_reg <= rose(line_driver_clock_source_ctrl_reg, drv_wr, `E1LC_TX_STORE_RESET_BIT);
        end
    end

    // Register readback
    assign rd_map = read_map(addr_s, line_reset_store_align_monitor_ctrl_reg, line_driver_clock_source_ctrl_reg);
    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            data_out_reg <= 8'h00;
            data_oe_reg  <= 1'b0;
        end
        else
        begin
            data_out_reg <= rd_map[7:0];
            data_oe_reg  <= rd_act & rd_map[8];
        end
    end

    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            tx_clk_rec_reg <= 1'b0;
            tx_pin_ign_reg <= 1'b0;
        end
        else
        begin
            tx_clk_rec_reg <= line_driver_clock_source_ctrl_reg[`E1LC_TX_CLK_SRC_BIT]
                              | (tx_clock_loss_mux_ctrl & tx_clock_lost);
            tx_pin_ign_reg <= line_driver_clock_source_ctrl_reg[`E1LC_TX_CLK_SRC_BIT];
        end
    end

    // 1010 pattern with alternating mark polarity when the disconnect bit is set, otherwise the bipolar inputs
    assign mark       = line_driver_clock_source_ctrl_reg[`E1LC_DISCONNECT_BIT] ? pat_bit_reg : (tx_pos_s | tx_neg_s);
    assign mark_pos   = line_driver_clock_source_ctrl_reg[`E1LC_DISCONNECT_BIT] ? (pat_bit_reg & ~mark_pol_reg)
                                                                                 : tx_pos_s;
    assign mark_neg   = line_driver_clock_source_ctrl_reg[`E1LC_DISCONNECT_BIT] ? (pat_bit_reg & mark_pol_reg)
                                                                                 : tx_neg_s;
    assign open_drain = line_driver_clock_source_ctrl_reg[`E1LC_OPEN_DRAIN_BIT];

    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            pat_bit_reg   <= 1'b1;
            mark_pol_reg  <= 1'b0;
            line_a_reg    <= 1'b0;
            line_a_oe_reg <= 1'b0;
            line_b_reg    <= 1'b0;
            line_b_oe_reg <= 1'b0;
        end
        else
        begin
            if (line_bit_tick)
            begin
                pat_bit_reg  <= ~pat_bit_reg;
                // Polarity only advances on a mark so the line stays DC free
                mark_pol_reg <= mark_pol_reg ^ (mark & line_driver_clock_source_ctrl_reg[`E1LC_DISCONNECT_BIT]);
            end
            if (open_drain)
            begin
                line_a_reg    <= 1'b0;
                line_a_oe_reg <= mark_pos;
                line_b_reg    <= 1'b0;
                line_b_oe_reg <= mark_neg;
            end
            else
            begin
                line_a_reg    <= mark_pos;
                line_a_oe_reg <= 1'b1;
                line_b_reg    <= mark_neg;
                line_b_oe_reg <= 1'b1;
            end
        end
    end

    // store commands held into backplane domains
    e1lc_cmd_xfer #(.EDGES(BP_EDGES)) u_rx_align (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .trig       (rx_align_trig_reg),
        .bp_clk_pin (rx_backplane_clock),
        .cmd_out    (rx_store_align),
        .busy       ()
    );

    e1lc_cmd_xfer #(.EDGES(BP_EDGES)) u_tx_align (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .trig       (tx_align_trig_reg),
        .bp_clk_pin (tx_backplane_clock),
        .cmd_out    (tx_store_align),
        .busy       ()
    );

    e1lc_cmd_xfer #(.EDGES(BP_EDGES)) u_rx_reset (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .trig       (rx_reset_trig_reg),
        .bp_clk_pin (rx_backplane_clock),
        .cmd_out    (rx_store_reset),
        .busy       ()
    );

    e1lc_cmd_xfer #(.EDGES(BP_EDGES)) u_tx_reset (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .trig       (tx_reset_trig_reg),
        .bp_clk_pin (tx_backplane_clock),
        .cmd_out    (tx_store_reset),
        .busy       ()
    );

    assign data_out                 = data_out_reg;
    assign data_oe                  = data_oe_reg;
    assign line_if_reset            = line_if_reset_reg;
    assign rx_chan_monitor_sel      = line_reset_store_align_monitor_ctrl_reg[`E1LC_RX_MON_SEL_MSB:`E1LC_RX_MON_SEL_LSB];
    assign line_rx_sync_signal_mode = line_driver_clock_source_ctrl_reg[`E1LC_SYNC_MODE_BIT];
    assign tx_clk_use_recovered     = tx_clk_rec_reg;
    assign tx_clock_pin_ignored     = tx_pin_ign_reg;
    assign line_tx_out_a            = line_a_reg;
    assign line_tx_out_a_oe         = line_a_oe_reg;
    assign line_tx_out_b            = line_b_reg;
    assign line_tx_out_b_oe         = line_b_oe_reg;

endmodule

// *** design/e1lc_regs.vh ***
// Offsets, field positions, reset values and timing counts of the line and store command control registers
`ifndef E1LC_REGS_VH
`define E1LC_REGS_VH

// Register byte addresses on the parallel control port
`define E1LC_LINE_RST_ALIGN_MON_ADDR   8'hAA
`define E1LC_DRV_CLK_SRC_ADDR          8'h1D

// Fields of line_reset_store_align_monitor_ctrl
`define E1LC_LINE_IF_RESET_BIT         7
`define E1LC_RX_ALIGN_BIT              6
`define E1LC_TX_ALIGN_BIT              5
`define E1LC_RX_MON_SEL_MSB            4
`define E1LC_RX_MON_SEL_LSB            0

// Fields of line_driver_clock_source_ctrl
`define E1LC_OPEN_DRAIN_BIT            7
`define E1LC_DISCONNECT_BIT            6
`define E1LC_SYNC_MODE_BIT             5
`define E1LC_UNUSED_HI_BIT             4
`define E1LC_UNUSED_LO_BIT             3
`define E1LC_TX_CLK_SRC_BIT            2
`define E1LC_RX_STORE_RESET_BIT        1
`define E1LC_TX_STORE_RESET_BIT        0

// Reset values
`define E1LC_LINE_RST_ALIGN_MON_RST    8'h00
`define E1LC_DRV_CLK_SRC_RST           8'h00

// Unassigned bits of the drive register read back as zero
`define E1LC_DRV_CLK_SRC_MASK          8'hE7

// Backplane clock rising edges a command is held across
`define E1LC_BP_EDGES                  2

`endif

// *** tb/e1lc_ctrl_properties.sv ***
// Port-level checks for the line and store command control registers
module e1lc_ctrl_properties #(
    parameter BP_EDGES = 2
) (
    // Clock, reset and control port
    input wire       core_clk, nrst, cs_n, rd_n, wr_n,
    input wire [7:0] addr, data_in, data_out,
    input wire       data_oe,
    // Backplane and store status
    input wire       rx_backplane_clock, tx_backplane_clock, rx_store_sep_ge_half, tx_store_sep_ge_half,
    // Transmit clock and line data
    input wire       tx_clock_loss_mux_ctrl, tx_clock_lost, line_bit_tick, tx_bipolar_in_pos, tx_bipolar_in_neg,
    input wire       line_tx_out_a, line_tx_out_a_oe, line_tx_out_b, line_tx_out_b_oe,
    // Commands and settings
    input wire       line_if_reset, rx_store_align, tx_store_align, rx_store_reset, tx_store_reset,
    input wire [4:0] rx_chan_monitor_sel,
    input wire       line_rx_sync_signal_mode, tx_clk_use_recovered, tx_clock_pin_ignored
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] since_wr;

    // Cycles since the write strobe was last seen low, saturating
    always @(posedge core_clk)
    begin
        if (!nrst || (!cs_n && !wr_n))
            since_wr <= 4'h0;
        else if (since_wr != 4'hF)
            since_wr <= since_wr + 4'h1;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_reset_one_cycle: assert property (line_if_reset |=> !line_if_reset)
        else $error("line reset pulse longer than one cycle");
    a_reset_after_write: assert property (line_if_reset |-> since_wr inside {[2:10]})
        else $error("line reset pulse without a recent write");
    a_sel_after_write: assert property (!$stable(rx_chan_monitor_sel) |-> since_wr inside {[2:10]})
        else $error("monitor select changed without a recent write");
    a_rx_align_hold: assert property ($rose(rx_store_align) |-> rx_store_align[*2] ##[1:40] !rx_store_align)
        else $error("receive align hold out of range");
    a_tx_reset_hold: assert property ($rose(tx_store_reset) |-> tx_store_reset[*2] ##[1:40] !tx_store_reset)
        else $error("transmit store reset hold out of range");
    a_drive_enc: assert property (!((line_tx_out_a && !line_tx_out_a_oe) || (line_tx_out_b && !line_tx_out_b_oe)))
        else $error("line output high while not enabled");
    a_src_forced: assert property (tx_clock_pin_ignored && $past(tx_clock_pin_ignored) |-> tx_clk_use_recovered)
        else $error("recovered clock not used while forced");
    a_src_mux: assert property ($past(nrst) && !tx_clock_pin_ignored && !$past(tx_clock_pin_ignored)
        |-> tx_clk_use_recovered == $past(tx_clock_loss_mux_ctrl && tx_clock_lost))
        else $error("clock source differs from loss mux choice");

    c_rx_align: cover property ($rose(rx_store_align));
    c_line_reset: cover property (line_if_reset);
    c_src_forced: cover property ($rose(tx_clock_pin_ignored));
endmodule

bind e1lc_ctrl e1lc_ctrl_properties #(.BP_EDGES(BP_EDGES)) u_props (.*);

// *** tb/tb.sv ***
// Self-checking bench for the line and store command control registers
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       core_clk, nrst, cs_n, rd_n, wr_n, rx_bp, tx_bp, rx_sep, tx_sep;
    logic       mux_ctrl, clk_lost, tick, pos_in, neg_in;
    logic [7:0] addr, data_in;
    wire  [7:0] data_out;
    wire  [4:0] cmd, mon_sel;
    wire        data_oe, out_a, oe_a, out_b, oe_b, sync_mode, use_rec, pin_ign;
    int         err_count = 0, checks_done = 0, cycles = 0;
    int         cmd_cnt[5];
    logic [4:0] cmd_prev = 5'h0;
    logic [1:0] m[4];

    e1lc_ctrl u_dut (.core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .rx_backplane_clock(rx_bp),
        .tx_backplane_clock(tx_bp), .rx_store_sep_ge_half(rx_sep), .tx_store_sep_ge_half(tx_sep),
        .tx_clock_loss_mux_ctrl(mux_ctrl), .tx_clock_lost(clk_lost), .line_bit_tick(tick),
        .tx_bipolar_in_pos(pos_in), .tx_bipolar_in_neg(neg_in), .line_tx_out_a(out_a), .line_tx_out_a_oe(oe_a),
        .line_tx_out_b(out_b), .line_tx_out_b_oe(oe_b), .line_if_reset(cmd[0]), .rx_store_align(cmd[1]),
        .tx_store_align(cmd[2]), .rx_store_reset(cmd[3]), .tx_store_reset(cmd[4]), .rx_chan_monitor_sel(mon_sel),
        .line_rx_sync_signal_mode(sync_mode), .tx_clk_use_recovered(use_rec), .tx_clock_pin_ignored(pin_ign));

    initial
    begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    // clocks stable first
    // Backplane clocks unrelated to each other; rx period is four core periods, tx unrelated to the core clock
    initial
    begin
        rx_bp = 0;
        forever #20 rx_bp = ~rx_bp;
    end
    initial
    begin
        tx_bp = 0;
        forever #24 tx_bp = ~tx_bp;
    end

    // Count command rising edges; also cut a hang short
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        cmd_prev <= cmd;
        for (int i = 0; i < 5; i++)
            if (cmd[i] && !cmd_prev[i])
                cmd_cnt[i] <= cmd_cnt[i] + 1;
        if (cycles == 5000)
        begin
            err_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Strobe held past the synchroniser, address and data held until the next access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        data_in = d;
        cs_n = 0;
        wr_n = 0;
        step(4);
        cs_n = 1;
        wr_n = 1;
        step(8);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_oe);
        addr = a;
        cs_n = 0;
        rd_n = 0;
        step(6);
        chk("read enable", {7'h0, exp_oe}, {7'h0, data_oe});
        if (exp_oe)
            chk("read data", exp, data_out);
        cs_n = 1;
        rd_n = 1;
        step(8);
    endtask

    // Write, let the command run its course, then count its rising edges
    task automatic wr_cmd(input logic [7:0] a, input logic [7:0] d, input int idx, input int n);
        cmd_cnt = '{default: 0};
        wr(a, d);
        step(20);
        chk("command count", n[7:0], cmd_cnt[idx][7:0]);
    endtask

    task automatic t_regs();
        rd(8'hAA, 8'h00, 1'b1);
        rd(8'h1D, 8'h00, 1'b1);
        rd(8'h55, 8'h00, 1'b0);
        wr(8'hAA, 8'h1F);
        chk("monitor select", 8'h1F, {3'h0, mon_sel});
        wr(8'h55, 8'hFF);
        rd(8'hAA, 8'h1F, 1'b1);
        wr(8'h1D, 8'h3C);
        rd(8'h1D, 8'h24, 1'b1);
        chk("sync mode", 8'h01, {7'h0, sync_mode});
        chk("pin ignored", 8'h01, {7'h0, pin_ign});
        chk("use recovered", 8'h01, {7'h0, use_rec});
        wr(8'hAA, 8'h01);
        chk("monitor select", 8'h01, {3'h0, mon_sel});
        wr(8'h1D, 8'h00);
        mux_ctrl = 1;
        clk_lost = 1;
        step(3);
        chk("use recovered", 8'h01, {7'h0, use_rec});
        chk("pin ignored", 8'h00, {7'h0, pin_ign});
        mux_ctrl = 0;
        step(3);
        chk("use recovered", 8'h00, {7'h0, use_rec});
        $display("Test registers done");
    endtask

    task automatic t_line_reset();
        wr_cmd(8'hAA, 8'h80, 0, 1);
        wr_cmd(8'hAA, 8'h80, 0, 0);
        wr(8'hAA, 8'h00);
        wr_cmd(8'hAA, 8'h80, 0, 1);
        wr(8'hAA, 8'h00);
        $display("Test line reset done");
    endtask

    task automatic t_align();
        wr_cmd(8'hAA, 8'h40, 1, 1);
        wr_cmd(8'hAA, 8'h40, 1, 0);
        wr(8'hAA, 8'h00);
        wr_cmd(8'hAA, 8'h20, 2, 1);
        wr(8'hAA, 8'h00);
        rx_sep = 1;
        tx_sep = 1;
        wr_cmd(8'hAA, 8'h40, 1, 0);
        wr(8'hAA, 8'h00);
        wr_cmd(8'hAA, 8'h20, 2, 0);
        rx_sep = 0;
        tx_sep = 0;
        wr(8'hAA, 8'h00);
        $display("Test align done");
    endtask

    task automatic t_store_reset();
        wr_cmd(8'h1D, 8'h02, 3, 1);
        wr_cmd(8'h1D, 8'h03, 4, 1);
        chk("rx reset count", 8'h00, cmd_cnt[3][7:0]);
        wr(8'h1D, 8'h00);
        $display("Test store reset done");
    endtask

    task automatic t_line_out();
        pos_in = 1;
        step(6);
        chk("normal drive", 8'h0D, {4'h0, out_a, oe_a, out_b, oe_b});
        wr(8'h1D, 8'h80);
        chk("open drain", 8'h04, {4'h0, out_a, oe_a, out_b, oe_b});
        pos_in = 0;
        wr(8'h1D, 8'h40);
        // Pattern starts on a mark, so each bit is sampled before the tick advances it
        for (int i = 0; i < 4; i++)
        begin
            m[i] = {out_a, out_b};
            tick = 1;
            step(1);
            tick = 0;
            step(4);
        end
        chk("pattern marks", 8'h0A, {4'h0, |m[0], |m[1], |m[2], |m[3]});
        chk("mark polarity", 8'h03, {6'h0, m[0] ^ m[2]});
        wr(8'h1D, 8'h00);
        $display("Test line output done");
    endtask

    initial
    begin
        {nrst, rx_sep, tx_sep, mux_ctrl, clk_lost, tick, pos_in, neg_in} = 8'h00;
        {cs_n, rd_n, wr_n} = 3'h7;
        addr = 8'h00;
        data_in = 8'h00;
        cmd_cnt = '{default: 0};
        // Reset held for two clock cycles; synchronisers clear to inactive
        step(2);
        nrst = 1;
        step(2);
        t_regs();
        t_line_reset();
        t_align();
        t_store_reset();
        t_line_out();
        test_done();
    end
endmodule
